/* File: logic/afe_map.vh */
`ifndef AFE_MAP_VH
`define AFE_MAP_VH

// register indices; byte address on the bus is four times the index
`define AFE_IDX_CH0 6'h00
`define AFE_IDX_CH1 6'h01
`define AFE_IDX_MOD 6'h08
`define AFE_IDX_PHASE 6'h0A
`define AFE_IDX_GAIN 6'h0B
`define AFE_IDX_STATCOM 6'h0C
`define AFE_IDX_CFGA 6'h0D
`define AFE_IDX_CFGB 6'h0E
`define AFE_IDX_OFF0 6'h0F
`define AFE_IDX_GCAL0 6'h10
`define AFE_IDX_OFF1 6'h11
`define AFE_IDX_GCAL1 6'h12
`define AFE_IDX_SECUR 6'h1F
`define AFE_IDX_LOOP_PTR 6'h20
`define AFE_IDX_LOOP_DATA 6'h21
`define AFE_MAP_LAST 5'h1F

// reset values
`define AFE_RST_MOD 24'h000033
`define AFE_RST_STATCOM 24'hA90000
`define AFE_RST_ZERO 24'h000000

// implemented bits
`define AFE_MASK_MOD 24'h0000FF
`define AFE_MASK_PHASE 24'h000FFF
`define AFE_MASK_GAIN 24'h00003F

// status and communication fields
`define AFE_SC_READ_HI 23
`define AFE_SC_READ_LO 22
`define AFE_SC_WRITE 21
`define AFE_SC_WIDTH_HI 17
`define AFE_SC_WIDTH_LO 16

// configuration_a fields
`define AFE_CA_EN_OFFCAL 2
`define AFE_CA_GAIN_CORRECTION_ENABLE 1

// read-loop codes
`define AFE_RL_STATIC 2'h0
`define AFE_RL_GROUP 2'h1
`define AFE_RL_TYPE 2'h2
`define AFE_RL_MAP 2'h3

// output word widths
`define AFE_WD_16 2'h0
`define AFE_WD_24 2'h1
`define AFE_WD_32Z 2'h2
`define AFE_WD_32S 2'h3

// gain correction is a signed fraction with this many fraction bits
`define AFE_GCAL_FRAC 23

`endif

/* File: logic/afe_regmap.v */
`timescale 1ns/1ps
`default_nettype none
`include "afe_map.vh"

// Summary of operation
// RULE1: every register is 24 bits wide and can be read alone at its own address.
// RULE2: channel data are returned in the word width chosen by the data-width field.
// RULE3: a two-bit read-loop field and a one-bit write-loop bit choose the address set for streams.
// RULE4: read loop 11 walks the whole map, 10 one type, 01 one group, 00 stays put.
// RULE5: write loop 1 walks the writable type, 0 stays put, channel data never take writes.
// RULE6: index 0x00 returns the channel zero result, read-only, MSB first.
// RULE7: index 0x01 returns the channel one result, read-only, MSB first.
// RULE8: index 0x08 is read/write and follows the modulator outputs.
// RULE9: index 0x0A holds the phase delay and 0x0B the amplifier gain, both read/write.
// RULE10: index 0x0C holds status and communication, 0x0D and 0x0E the two configurations.
// RULE11: index 0x0F holds the channel zero offset and 0x10 its gain correction.
// RULE12: index 0x11 holds the channel one offset and 0x12 its gain correction.
// RULE13: index 0x1F holds the lock password and the map checksum.
// RULE14: with gain correction enabled each channel result is scaled by its gain correction.
// RULE15: channel results are held while a read is in progress, new samples wait.
// RULE16: unused indices read zero and ignore writes.
// RULE17: a stream past the end of its set wraps to the first address of that set.
module afe_regmap #(
  parameter DW = 24
) (
  input wire i_mclk,
  input wire i_rstn,
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  input wire i_drdy,
  input wire [DW-1:0] i_ch0_raw,
  input wire [DW-1:0] i_ch1_raw,
  input wire i_mod_valid,
  input wire [7:0] i_mod_bits,
  input wire [15:0] i_map_crc,
  output reg [DW-1:0] o_phase,
  output reg [DW-1:0] o_gain,
  output reg [DW-1:0] o_statcom,
  output reg [DW-1:0] o_config_a,
  output reg [DW-1:0] o_config_b,
  output reg o_adc_restart
);

  reg ack_r;
  reg [DW-1:0] ch0_r;
  reg [DW-1:0] ch1_r;
  reg [DW-1:0] ch0_pend_r;
  reg [DW-1:0] ch1_pend_r;
  reg pend_r;
  reg [DW-1:0] mod_r;
  reg [DW-1:0] off0_r;
  reg [DW-1:0] gcal0_r;
  reg [DW-1:0] off1_r;
  reg [DW-1:0] gcal1_r;
  reg [7:0] passwd_r;
  reg [4:0] loop_ptr_r;
  reg [4:0] loop_ptr_nxt;
  reg [31:0] rdata_nxt;
  reg [DW-1:0] word;
  wire [5:0] idx;
  wire [4:0] acc_addr;
  wire loop_acc;
  wire wr_go;
  wire rd_go;
  wire [DW-1:0] wdata;
  wire [DW-1:0] ch0_corr;
  wire [DW-1:0] ch1_corr;
  wire [1:0] read_loop;
  wire write_loop;
  wire [1:0] width_sel;

  assign idx = i_avs_address[7:2];
  assign loop_acc = (idx == `AFE_IDX_LOOP_DATA);
  assign acc_addr = loop_acc ? loop_ptr_r : idx[4:0];
  assign wdata = i_avs_writedata[DW-1:0];
  assign read_loop = o_statcom[`AFE_SC_READ_HI:`AFE_SC_READ_LO]; // RULE3
  assign write_loop = o_statcom[`AFE_SC_WRITE]; // RULE3
  assign width_sel = o_statcom[`AFE_SC_WIDTH_HI:`AFE_SC_WIDTH_LO];

  // one wait cycle on every access; the answer comes on the second edge
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
  assign wr_go = i_avs_write & ack_r;
  assign rd_go = i_avs_read & ack_r;

  // offset then signed gain fraction: out = x + x*g/2^23
  function [DW-1:0] correct;
    input [DW-1:0] x;
    input [DW-1:0] off;
    input [DW-1:0] g;
    input en_off;
    input en_gain;
    reg [DW-1:0] y;
    reg signed [2*DW-1:0] prod;
    begin
      y = en_off ? x + off : x;
      prod = $signed(y) * $signed(g);
      correct = en_gain ? y + prod[`AFE_GCAL_FRAC+DW-1:`AFE_GCAL_FRAC] : y; // RULE14
    end
  endfunction

  assign ch0_corr = correct(i_ch0_raw, off0_r, gcal0_r,
    o_config_a[`AFE_CA_EN_OFFCAL], o_config_a[`AFE_CA_GAIN_CORRECTION_ENABLE]);
  assign ch1_corr = correct(i_ch1_raw, off1_r, gcal1_r,
    o_config_a[`AFE_CA_EN_OFFCAL], o_config_a[`AFE_CA_GAIN_CORRECTION_ENABLE]);

  // output word shaping for the channel data
  function [31:0] fmt;
    input [DW-1:0] d;
    input [1:0] w;
    begin
      case (w)
        `AFE_WD_16: fmt = {16'h0000, d[DW-1:DW-16]};
        `AFE_WD_24: fmt = {8'h00, d};
        `AFE_WD_32Z: fmt = {d, 8'h00};
        `AFE_WD_32S: fmt = {{8{d[DW-1]}}, d};
        default: fmt = {8'h00, d};
      endcase
    end
  endfunction

  // last and first address of the set that a stream walks
  function [4:0] set_first;
    input [4:0] a;
    input [1:0] mode;
    begin
      case (mode)
        `AFE_RL_MAP: set_first = 5'h00;
        `AFE_RL_TYPE: set_first = (a <= `AFE_IDX_CH1) ? 5'h00 : 5'h08;
        `AFE_RL_GROUP: begin
          if (a <= 5'h01) begin
            set_first = 5'h00;
          end else if (a <= 5'h0B) begin
            set_first = 5'h08;
          end else if (a <= 5'h0E) begin
            set_first = 5'h0C;
          end else if (a <= 5'h10) begin
            set_first = 5'h0F;
          end else if (a <= 5'h12) begin
            set_first = 5'h11;
          end else begin
            set_first = 5'h1F;
          end
        end
        default: set_first = a;
      endcase
    end
  endfunction

  function [4:0] set_last;
    input [4:0] a;
    input [1:0] mode;
    begin
      case (mode)
        `AFE_RL_MAP: set_last = `AFE_MAP_LAST;
        `AFE_RL_TYPE: set_last = (a <= `AFE_IDX_CH1) ? 5'h01 : `AFE_MAP_LAST;
        `AFE_RL_GROUP: begin
          if (a <= 5'h01) begin
            set_last = 5'h01;
          end else if (a <= 5'h0B) begin
            set_last = 5'h0B;
          end else if (a <= 5'h0E) begin
            set_last = 5'h0E;
          end else if (a <= 5'h10) begin
            set_last = 5'h10;
          end else if (a <= 5'h12) begin
            set_last = 5'h12;
          end else begin
            set_last = 5'h1F;
          end
        end
        default: set_last = a;
      endcase
    end
  endfunction

  function [4:0] step;
    input [4:0] a;
    input [1:0] mode;
    begin
      if (a == set_last(a, mode)) begin
        step = set_first(a, mode); // RULE17
      end else begin
        step = a + 5'h01;
      end
    end
  endfunction

  // read mux
  always @* begin
    word = `AFE_RST_ZERO;
    case (acc_addr)
      5'h00: word = ch0_r; // RULE6
      5'h01: word = ch1_r; // RULE7
      5'h08: word = mod_r & `AFE_MASK_MOD; // RULE8
      5'h0A: word = o_phase; // RULE9
      5'h0B: word = o_gain;
      5'h0C: word = o_statcom; // RULE10
      5'h0D: word = o_config_a;
      5'h0E: word = o_config_b;
      5'h0F: word = off0_r; // RULE11
      5'h10: word = gcal0_r;
      5'h11: word = off1_r; // RULE12
      5'h12: word = gcal1_r;
      5'h1F: word = {passwd_r, i_map_crc}; // RULE13
      default: word = `AFE_RST_ZERO; // RULE16
    endcase
    if (idx == `AFE_IDX_LOOP_PTR) begin
      rdata_nxt = {27'h0000000, loop_ptr_r};
    end else if (idx > `AFE_IDX_LOOP_DATA) begin
      rdata_nxt = 32'h00000000;
    end else if (acc_addr <= 5'h01) begin
      rdata_nxt = fmt(word, width_sel); // RULE2
    end else begin
      rdata_nxt = {8'h00, word}; // RULE1
    end
  end

  // stream pointer movement
  always @* begin
    loop_ptr_nxt = loop_ptr_r;
    if (wr_go && idx == `AFE_IDX_LOOP_PTR) begin
      loop_ptr_nxt = i_avs_writedata[4:0];
    end else if (rd_go && loop_acc) begin
      loop_ptr_nxt = step(loop_ptr_r, read_loop); // RULE4
    end else if (wr_go && loop_acc && write_loop && loop_ptr_r >= `AFE_IDX_MOD) begin
      loop_ptr_nxt = step(loop_ptr_r, `AFE_RL_TYPE); // RULE5
    end
  end

  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      ack_r <= 1'b0;
      o_avs_readdata <= 32'h00000000;
      loop_ptr_r <= 5'h00;
    end else begin
      ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
      if (i_avs_read && !ack_r) begin
        o_avs_readdata <= rdata_nxt;
      end
      loop_ptr_r <= loop_ptr_nxt;
    end
  end

  // channel results: a sample that lands during a read is parked
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      ch0_r <= `AFE_RST_ZERO;
      ch1_r <= `AFE_RST_ZERO;
      ch0_pend_r <= `AFE_RST_ZERO;
      ch1_pend_r <= `AFE_RST_ZERO;
      pend_r <= 1'b0;
    end else if (i_avs_read) begin
      if (i_drdy) begin
        ch0_pend_r <= ch0_corr; // RULE15
        ch1_pend_r <= ch1_corr;
        pend_r <= 1'b1;
      end
    end else if (i_drdy) begin
      ch0_r <= ch0_corr;
      ch1_r <= ch1_corr;
      pend_r <= 1'b0;
    end else if (pend_r) begin
      ch0_r <= ch0_pend_r; // RULE15
      ch1_r <= ch1_pend_r;
      pend_r <= 1'b0;
    end
  end

  // writable registers; writes to data and unused indices fall through
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      mod_r <= `AFE_RST_MOD;
      o_phase <= `AFE_RST_ZERO;
      o_gain <= `AFE_RST_ZERO;
      o_statcom <= `AFE_RST_STATCOM;
      o_config_a <= `AFE_RST_ZERO;
      o_config_b <= `AFE_RST_ZERO;
      off0_r <= `AFE_RST_ZERO;
      gcal0_r <= `AFE_RST_ZERO;
      off1_r <= `AFE_RST_ZERO;
      gcal1_r <= `AFE_RST_ZERO;
      passwd_r <= 8'h00;
      o_adc_restart <= 1'b0;
    end else begin
      o_adc_restart <= 1'b0;
      // modulator bits follow the converter; a bus write wins for that cycle only
      if (i_mod_valid) begin
        mod_r <= {16'h0000, i_mod_bits}; // RULE8
      end
      if (wr_go && idx <= `AFE_IDX_LOOP_DATA) begin
        case (acc_addr)
          5'h08: mod_r <= wdata & `AFE_MASK_MOD; // RULE8
          5'h0A: begin
            o_phase <= wdata & `AFE_MASK_PHASE; // RULE9
            o_adc_restart <= 1'b1;
          end
          5'h0B: o_gain <= wdata & `AFE_MASK_GAIN; // RULE9
          5'h0C: o_statcom <= wdata; // RULE10
          5'h0D: o_config_a <= wdata; // RULE10
          5'h0E: o_config_b <= wdata; // RULE10
          5'h0F: off0_r <= wdata; // RULE11
          5'h10: gcal0_r <= wdata; // RULE11
          5'h11: off1_r <= wdata; // RULE12
          5'h12: gcal1_r <= wdata; // RULE12
          5'h1F: passwd_r <= wdata[23:16]; // RULE13
          default: passwd_r <= passwd_r; // RULE16
        endcase
      end
    end
  end

endmodule // afe_regmap
`default_nettype wire

/* File: bench/afe_regmap_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module afe_regmap_chk #(
  parameter DW = 24
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [15:0] i_map_crc,
  input wire logic [DW-1:0] o_phase,
  input wire logic [DW-1:0] o_gain,
  input wire logic [DW-1:0] o_config_a,
  input wire logic o_adc_restart
);
  wire wr_ok = i_avs_write & ~o_avs_waitrequest;
  wire rd_ok = i_avs_read & ~o_avs_waitrequest;
  wire [5:0] idx = i_avs_address[7:2];
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  AST_ONE_WAIT: assert property ((i_avs_read | i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("request waited more than one cycle");
  AST_UNUSED_ZERO: assert property (rd_ok && (idx inside {[2:7], 9, [19:30]})
    |-> o_avs_readdata == 32'h00000000) else $error("unused index read non-zero");
  AST_UPPER_ZERO: assert property (rd_ok && idx > 6'h01 && idx < 6'h20
    |-> o_avs_readdata[31:24] == 8'h00) else $error("register wider than 24 bits");
  AST_CRC_SHOWN: assert property (rd_ok && idx == 6'h1F
    |-> o_avs_readdata[15:0] == $past(i_map_crc)) else $error("checksum not shown");
  AST_PHASE_WR: assert property (wr_ok && idx == 6'h0A
    |=> o_phase == ($past(i_avs_writedata[23:0]) & 24'h000FFF)) else $error("phase not written");
  AST_GAIN_WR: assert property (wr_ok && idx == 6'h0B
    |=> o_gain == ($past(i_avs_writedata[23:0]) & 24'h00003F)) else $error("gain not written");
  AST_RESTART: assert property (wr_ok && idx == 6'h0A
    |=> o_adc_restart ##1 !o_adc_restart) else $error("restart pulse wrong");
  AST_CFGA_HOLD: assert property (!$stable(o_config_a)
    |-> $past(wr_ok && idx == 6'h0D)) else $error("configuration changed without write");
  cover property (rd_ok && idx == 6'h00);
  cover property (wr_ok && idx == 6'h0A);
  cover property (rd_ok && idx == 6'h21);
endmodule // afe_regmap_chk
bind afe_regmap afe_regmap_chk #(.DW(DW)) u_chk (.i_mclk(i_mclk), .i_rstn(i_rstn),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_map_crc(i_map_crc), .o_phase(o_phase),
  .o_gain(o_gain), .o_config_a(o_config_a), .o_adc_restart(o_adc_restart));
`default_nettype wire

/* File: bench/afe_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module afe_host_model (
  input wire logic i_mclk,
  input wire logic i_waitrequest,
  input wire logic [31:0] i_readdata,
  output logic [7:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata
);
  initial begin
    o_address = 8'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v,
                      output logic [31:0] d);
    @(posedge i_mclk);
    o_address <= a;
    o_writedata <= v;
    o_write <= w;
    o_read <= !w;
    do @(posedge i_mclk); while (i_waitrequest !== 1'b0);
    d = i_readdata;
    o_read <= 1'b0;
    o_write <= 1'b0;
    // idle bus shows inverted values so a stale address or word never passes
    o_address <= ~a;
    o_writedata <= ~v;
  endtask
endmodule // afe_host_model
`default_nettype wire

/* File: bench/test_afe_register_map.sv */
`timescale 1ns/1ps
`default_nettype none
module test_afe_register_map;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_drdy = 1'b0;
  logic i_mod_valid = 1'b0;
  logic [23:0] i_ch0_raw = 24'h000000;
  logic [23:0] i_ch1_raw = 24'h000000;
  logic [7:0] i_mod_bits = 8'h00;
  logic [15:0] i_map_crc = 16'hBEEF;
  wire [7:0] adr;
  wire rd, wr, wt, restart;
  wire [31:0] wd, rdat;
  wire [23:0] phase, gain, statcom, cfga, cfgb;
  int error_cnt = 0;
  int comparisons = 0;
  logic [55:0] rows [12] = '{56'h20_FFFFFF_0000FF, 56'h28_ABCDEF_000DEF, 56'h2C_FFFFFF_00003F,
    56'h3C_123456_123456, 56'h40_654321_654321, 56'h44_0F0F0F_0F0F0F, 56'h48_F0F0F0_F0F0F0,
    56'h7C_5A1234_5ABEEF, 56'h08_FFFFFF_000000, 56'h24_FFFFFF_000000, 56'h4C_FFFFFF_000000,
    56'h78_FFFFFF_000000};
  // stream cases: loop code 3 bits, start pointer, next pointer, write flag
  logic [13:0] sm [6] = '{{3'b110, 5'h1F, 5'h00, 1'b0}, {3'b100, 5'h1F, 5'h08, 1'b0},
    {3'b010, 5'h12, 5'h11, 1'b0}, {3'b000, 5'h0B, 5'h0B, 1'b0}, {3'b001, 5'h1F, 5'h08, 1'b1},
    {3'b000, 5'h0F, 5'h0F, 1'b1}};
  logic [31:0] x;
  always #20 i_mclk = ~i_mclk;
  afe_regmap dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wt),
    .i_drdy(i_drdy), .i_ch0_raw(i_ch0_raw), .i_ch1_raw(i_ch1_raw), .i_mod_valid(i_mod_valid),
    .i_mod_bits(i_mod_bits), .i_map_crc(i_map_crc), .o_phase(phase), .o_gain(gain),
    .o_statcom(statcom), .o_config_a(cfga), .o_config_b(cfgb), .o_adc_restart(restart));
  afe_host_model u_host (.i_mclk(i_mclk), .i_waitrequest(wt), .i_readdata(rdat),
    .o_address(adr), .o_read(rd), .o_write(wr), .o_writedata(wd));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    u_host.xfer(1'b1, a, v, d);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    u_host.xfer(1'b0, a, 32'h00000000, d);
    check(d, exp);
  endtask
  task automatic sample(input logic [23:0] a, input logic [23:0] b);
    @(posedge i_mclk);
    i_ch0_raw <= a;
    i_ch1_raw <= b;
    i_drdy <= 1'b1;
    @(posedge i_mclk);
    i_drdy <= 1'b0;
  endtask
  function automatic logic [31:0] fmt(input logic [1:0] w, input logic [23:0] v);
    case (w)
      2'h0: fmt = {16'h0000, v[23:8]};
      2'h1: fmt = {8'h00, v};
      2'h2: fmt = {v, 8'h00};
      default: fmt = {{8{v[23]}}, v};
    endcase
  endfunction
  task give_verdict;
    $display("compares %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // about 200 transfer cycles are needed; allow a hundred times that
  initial begin
    #800000;
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (3) @(posedge i_mclk);
    i_rstn <= 1'b1;
    rreg(8'h30, 32'h00A90000);
    rreg(8'h20, 32'h00000033);
    foreach (rows[i]) begin
      wreg(rows[i][55:48], {8'h00, rows[i][47:24]});
      rreg(rows[i][55:48], {8'h00, rows[i][23:0]});
    end
    $display("table done");
    sample(24'h812345, 24'h7ABCDE);
    for (int w = 0; w < 4; w++) begin
      wreg(8'h30, {14'h0000, w[1:0], 16'h0000});
      rreg(8'h00, fmt(w[1:0], 24'h812345));
      rreg(8'h04, fmt(w[1:0], 24'h7ABCDE));
    end
    wreg(8'h30, 32'h00010000);
    $display("formats done");
    fork
      rreg(8'h00, 32'h00812345);
      begin
        repeat (2) @(posedge i_mclk);
        i_ch0_raw <= 24'h100000;
        i_drdy <= 1'b1;
        @(posedge i_mclk);
        i_drdy <= 1'b0;
      end
    join
    rreg(8'h00, 32'h00100000);
    wreg(8'h40, 32'h00400000);
    wreg(8'h34, 32'h00000002);
    sample(24'h100000, 24'h7ABCDE);
    rreg(8'h00, 32'h00180000);
    @(posedge i_mclk);
    i_mod_bits <= 8'hA5;
    i_mod_valid <= 1'b1;
    @(posedge i_mclk);
    i_mod_valid <= 1'b0;
    rreg(8'h20, 32'h000000A5);
    $display("latch and gain done");
    foreach (sm[k]) begin
      wreg(8'h30, {8'h00, sm[k][13:11], 5'h01, 16'h0000});
      wreg(8'h80, {27'h0, sm[k][10:6]});
      u_host.xfer(sm[k][0], 8'h84, 32'h00000000, x);
      rreg(8'h80, {27'h0, sm[k][5:1]});
    end
    $display("streams done");
    @(posedge i_mclk);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rstn <= 1'b1;
    check({8'h00, statcom}, 32'h00A90000);
    check({8'h00, phase}, 32'h00000000);
    rreg(8'h20, 32'h00000033);
    $display("reset done");
    give_verdict;
  end
endmodule // test_afe_register_map
`default_nettype wire
